// [common/isdb_pkg.sv]
/*
  Package for the interlock serial diagnostic byte set: field positions of the
  request, response, warning detail and fault detail bytes, plus timing counts.
  Assumes a single 40 MHz clock and one exchange strobe per chain cycle.
*/
package isdb_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ           = 40_000_000;
  localparam int unsigned WARN_PROMOTE_MIN = 30;
  // Promotion delay in seconds, then clock cycles per 1 s tick
  localparam int unsigned WARN_PROMOTE_S   = WARN_PROMOTE_MIN * 60;
  localparam int unsigned SEC_DIV_CYCLES   = CLK_HZ;

  // ****************************************************************
  // Request byte fields
  // ****************************************************************
  localparam int unsigned REQ_MAGNET_BIT = 0;
  localparam int unsigned REQ_RESET_BIT  = 7;
  localparam logic [7:0]  REQ_RESET_VAL  = 8'h00;

  // ****************************************************************
  // Response byte fields
  // ****************************************************************
  localparam int unsigned RSP_OUT_ACT_BIT   = 0;
  localparam int unsigned RSP_LOCKABLE_BIT  = 1;
  localparam int unsigned RSP_LOCKED_BIT    = 2;
  localparam int unsigned RSP_INPUTS_BIT    = 4;
  localparam int unsigned RSP_ACT_VALID_BIT = 5;
  localparam int unsigned RSP_WARN_BIT      = 6;
  localparam int unsigned RSP_FAULT_BIT     = 7;

  // ****************************************************************
  // Detail byte fields (shared meaning)
  // ****************************************************************
  localparam int unsigned DET_OUT_A_BIT   = 0;
  localparam int unsigned DET_OUT_B_BIT   = 1;
  localparam int unsigned DET_XWIRE_BIT   = 2;
  localparam int unsigned DET_TEMP_BIT    = 3;
  localparam int unsigned DET_ACTUATOR_BIT = 4;
  localparam int unsigned DET_INTERNAL_BIT = 5;
  localparam int unsigned DET_COMM_BIT    = 6;
  localparam int unsigned DET_HANDLE_BIT  = 7;
  localparam logic [7:0]  BYTE_RESET_VAL  = 8'h00;

  // Conditions sensed by the device, sampled from pins
  typedef struct packed {
    logic guardClosed;
    logic actuatorValid;
    logic actuatorLocked;
    logic turretAtRest;
    logic turretOverPulled;
    logic safetyInputA;
    logic safetyInputB;
    logic outAFault;
    logic outBFault;
    logic crossWire;
    logic overTemp;
    logic actuatorBad;
    logic internalErr;
    logic handleMisplaced;
  } isdb_sense_t;

  // Bytes returned to the gateway
  typedef struct packed {
    logic [7:0] response;
    logic [7:0] warning;
    logic [7:0] fault;
  } isdb_reply_t;

endpackage : isdb_pkg

// [hw/isdb_diag_bytes.sv]
/*
  Interlock serial diagnostic byte set: takes the request byte from each good
  chain exchange, drives the magnet, latches faults, promotes stale warnings
  and returns response, warning and fault detail bytes.
  Assumes sensed conditions and the exchange strobe come from pins (two-flop
  synchronised here) and that the chain framing lives elsewhere.
*/
// Summary of operation
// - Request bit 0 energises the magnet, whatever the lock principle.
// - Latched fault clears on request bit 7 falling, or guard opening, once cause gone.
// - Response bit 1 set only with guard closed and lock/unlock possible.
// - Response bit 0 outputs active, bit 2 actuator locked, bit 3 zero.
// - Response bit 4 both safety inputs, bit 5 valid actuator detected.
// - Response bit 6 pending warning, bit 7 fault switched off enabling path.
// - Detail cause bytes are available whenever warning or fault is flagged.
// - Warning byte bits 0-3, 5, 6, 7 carry the listed causes.
// - Fault byte uses same bits except bit 6, plus bit 4 for actuator or bracket defect.
// - Both detail bytes set bit 7 for a mispositioned rotary handle.
// - Warning in bits 0-3 pending thirty minutes becomes a fault and drops outputs.
// - Lock-possible cleared whenever the turret is out of rest position.
// - Unlock-possible cleared while the door over-pulls the turret.
// - Gateway communication loss holds the present switching condition.
`timescale 1ns/1ps
module isdb_diag_bytes (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  // Serial chain exchange, from the chain shifter
  input  wire logic                 xchgStrobe,
  input  wire logic                 xchgOk,
  input  wire logic [7:0]           requestCommandByte,
  // Sensed device conditions, from pins
  input  wire isdb_pkg::isdb_sense_t senseIn,
  // Device controls
  output logic                      magnetOn,
  output logic                      safetyOutputA,
  output logic                      safetyOutputB,
  // Bytes returned on the chain
  output isdb_pkg::isdb_reply_t     replyOut
);

  // ****************************************************************
  // Reset release and input synchronisers
  // ****************************************************************
  logic        rstMeta_r;
  logic        rstSync_r;
  logic        rst_n;

  // Asynchronous assert, two-flop release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end
  assign rst_n = rstSync_r;

  localparam int unsigned SW = $bits(isdb_pkg::isdb_sense_t);
  logic [SW+9:0] syncMeta_r;
  logic [SW+9:0] syncOut_r;
  isdb_pkg::isdb_sense_t sense;
  logic        xStb;
  logic        xOk;
  logic [7:0]  reqIn;

  // Two flops on every pin-sourced input; only stage two is read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncMeta_r <= '0;
      syncOut_r  <= '0;
    end else begin
      syncMeta_r <= {senseIn, xchgStrobe, xchgOk, requestCommandByte};
      syncOut_r  <= syncMeta_r;
    end
  end
  assign {sense, xStb, xOk, reqIn} = syncOut_r;

  // ****************************************************************
  // Exchange detection and request capture
  // ****************************************************************
  logic        xStbDly_r;
  logic        xchgEvt;
  logic [7:0]  request_r;
  logic        commErr_r;

  // Strobe can stay high many cycles; act once per rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) xStbDly_r <= 1'b0;
    else        xStbDly_r <= xStb;
  end
  assign xchgEvt = xStb & ~xStbDly_r;

  // A bad exchange leaves the last good request in force
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      request_r <= isdb_pkg::REQ_RESET_VAL;
      commErr_r <= 1'b0;
    end else if (xchgEvt) begin
      if (xOk) begin
        request_r <= reqIn;
        commErr_r <= 1'b0;
      end else begin
        commErr_r <= 1'b1;
      end
    end
  end

  // Magnet follows the request bit directly; polarity handled by driver stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) magnetOn <= 1'b0;
    else        magnetOn <= request_r[isdb_pkg::REQ_MAGNET_BIT];
  end

  // ****************************************************************
  // Seconds divider and warning promotion timer
  // ****************************************************************
  localparam int unsigned DW = $clog2(isdb_pkg::SEC_DIV_CYCLES);
  localparam int unsigned TW = $clog2(isdb_pkg::WARN_PROMOTE_S + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(isdb_pkg::SEC_DIV_CYCLES - 1);
  localparam logic [TW-1:0] PROMOTE_S = TW'(isdb_pkg::WARN_PROMOTE_S);

  logic [DW-1:0] divCnt_r;
  logic          secTick;
  logic [TW-1:0] warnSec_r;
  logic          warnAny;
  logic          promote;

  // One-second enable pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)                  divCnt_r <= '0;
    else if (divCnt_r == DIV_LAST) divCnt_r <= '0;
    else                         divCnt_r <= divCnt_r + DW'(1);
  end
  assign secTick = (divCnt_r == DIV_LAST);

  assign warnAny = sense.outAFault | sense.outBFault | sense.crossWire | sense.overTemp;

  // Counts only while a warning stays pending; cleared the moment it goes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)                           warnSec_r <= '0;
    else if (!warnAny)                    warnSec_r <= '0;
    else if (secTick && !promote)         warnSec_r <= warnSec_r + TW'(1);
  end
  assign promote = warnAny && (warnSec_r >= PROMOTE_S);

  // ****************************************************************
  // Fault latch
  // ****************************************************************
  logic [7:0] faultLatch_r;
  logic [7:0] faultCause;
  logic       resetFall;
  logic       guardOpenRise;
  logic       guardDly_r;
  logic       reqResetDly_r;

  // Immediate faults plus promoted warnings
  always_comb begin
    faultCause = isdb_pkg::BYTE_RESET_VAL;
    faultCause[isdb_pkg::DET_OUT_A_BIT]    = promote & sense.outAFault;
    faultCause[isdb_pkg::DET_OUT_B_BIT]    = promote & sense.outBFault;
    faultCause[isdb_pkg::DET_XWIRE_BIT]    = promote & sense.crossWire;
    faultCause[isdb_pkg::DET_TEMP_BIT]     = promote & sense.overTemp;
    faultCause[isdb_pkg::DET_ACTUATOR_BIT] = sense.actuatorBad;
    faultCause[isdb_pkg::DET_INTERNAL_BIT] = sense.internalErr;
    faultCause[isdb_pkg::DET_HANDLE_BIT]   = sense.handleMisplaced;
  end

  // Edge sources for the fault reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reqResetDly_r <= 1'b0;
      guardDly_r    <= 1'b0;
    end else begin
      reqResetDly_r <= request_r[isdb_pkg::REQ_RESET_BIT];
      guardDly_r    <= sense.guardClosed;
    end
  end
  assign resetFall     = reqResetDly_r & ~request_r[isdb_pkg::REQ_RESET_BIT];
  assign guardOpenRise = guardDly_r & ~sense.guardClosed;

  // Clear only bits whose cause is gone; a present cause wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) faultLatch_r <= isdb_pkg::BYTE_RESET_VAL;
    else if (resetFall || guardOpenRise) faultLatch_r <= faultCause;
    else faultLatch_r <= faultLatch_r | faultCause;
  end

  // ****************************************************************
  // Safety outputs
  // ****************************************************************
  logic enableOk;
  assign enableOk = sense.guardClosed & sense.actuatorLocked & sense.safetyInputA &
                    sense.safetyInputB & ~(|faultLatch_r) & ~(|faultCause);

  // Any latched fault removes the enabling path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      safetyOutputA <= 1'b0;
      safetyOutputB <= 1'b0;
    end else begin
      safetyOutputA <= enableOk;
      safetyOutputB <= enableOk;
    end
  end

  // ****************************************************************
  // Reply bytes
  // ****************************************************************
  logic [7:0] rspNow;
  logic [7:0] warnNow;
  logic       lockOk;
  logic       unlockOk;

  // Locking needs the turret at rest; unlocking is refused on over-pull
  assign lockOk   = sense.turretAtRest;
  assign unlockOk = ~sense.turretOverPulled;

  always_comb begin
    warnNow = isdb_pkg::BYTE_RESET_VAL;
    warnNow[isdb_pkg::DET_OUT_A_BIT]    = sense.outAFault;
    warnNow[isdb_pkg::DET_OUT_B_BIT]    = sense.outBFault;
    warnNow[isdb_pkg::DET_XWIRE_BIT]    = sense.crossWire;
    warnNow[isdb_pkg::DET_TEMP_BIT]     = sense.overTemp;
    warnNow[isdb_pkg::DET_INTERNAL_BIT] = sense.internalErr;
    warnNow[isdb_pkg::DET_COMM_BIT]     = commErr_r;
    warnNow[isdb_pkg::DET_HANDLE_BIT]   = sense.handleMisplaced;
  end

  always_comb begin
    rspNow = isdb_pkg::BYTE_RESET_VAL; // Bit 3 stays zero
    rspNow[isdb_pkg::RSP_OUT_ACT_BIT]   = safetyOutputA & safetyOutputB;
    rspNow[isdb_pkg::RSP_LOCKABLE_BIT]  = sense.guardClosed &
      (magnetOn ? unlockOk : lockOk);
    rspNow[isdb_pkg::RSP_LOCKED_BIT]    = sense.actuatorLocked;
    rspNow[isdb_pkg::RSP_INPUTS_BIT]    = sense.safetyInputA & sense.safetyInputB;
    rspNow[isdb_pkg::RSP_ACT_VALID_BIT] = sense.actuatorValid;
    rspNow[isdb_pkg::RSP_WARN_BIT]      = |warnNow;
    rspNow[isdb_pkg::RSP_FAULT_BIT]     = |faultLatch_r;
  end

  // Snapshot all three bytes on every exchange so they stay current
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      replyOut <= '0;
    end else if (xchgEvt) begin
      replyOut.response <= rspNow;
      replyOut.warning  <= warnNow;
      replyOut.fault    <= faultLatch_r;
    end
  end

endmodule : isdb_diag_bytes

// [sim/isdb_diag_monitor.sv]
/*
  Checker for the diagnostic byte set: relations between exchange, sense and reply.
  Assumes strobe phases of at least six cycles and sense held across each exchange.
*/
`timescale 1ns/1ps
module isdb_diag_monitor (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  arst_n,
  // Exchange and sensed conditions
  input wire logic                  xchgStrobe,
  input wire logic                  xchgOk,
  input wire logic [7:0]            requestCommandByte,
  input wire isdb_pkg::isdb_sense_t senseIn,
  // Design outputs
  input wire logic                  magnetOn,
  input wire logic                  safetyOutputA,
  input wire logic                  safetyOutputB,
  input wire isdb_pkg::isdb_reply_t replyOut
);
  // ********
  // Properties
  // ********
  // Six cycles after the strobe pin rises covers sync, snapshot and magnet update
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_magnet_follows: assert property ($rose(xchgStrobe) && xchgOk |-> ##6
    magnetOn == $past(requestCommandByte[0], 6)) else $error("magnet not per request");
  a_comm_hold: assert property ($rose(xchgStrobe) && !xchgOk |-> ##6
    magnetOn == $past(magnetOn, 6)) else $error("magnet moved on bad exchange");
  a_guard_open: assert property ($rose(xchgStrobe) && !senseIn.guardClosed |-> ##6
    !replyOut.response[1]) else $error("lockable with guard open");
  a_lock_rest: assert property ($rose(xchgStrobe) && !magnetOn &&
    !senseIn.turretAtRest |-> ##6 !replyOut.response[1]) else $error("lockable off rest");
  a_unlock_pull: assert property ($rose(xchgStrobe) && magnetOn &&
    senseIn.turretOverPulled |-> ##6 !replyOut.response[1]) else $error("unlock over pull");
  a_inputs_pair: assert property ($rose(xchgStrobe) |-> ##6 replyOut.response[4] ==
    (senseIn.safetyInputA && senseIn.safetyInputB)) else $error("input pair bit wrong");
  a_handle_both: assert property ($rose(xchgStrobe) && senseIn.handleMisplaced
    |-> ##6 replyOut.warning[7] && replyOut.fault[7]) else $error("handle bits missing");
  a_bit3_zero: assert property (replyOut.response[3] == 1'b0)
    else $error("unused response bit set");
  a_warn_detail: assert property (replyOut.response[6] |-> replyOut.warning != 8'h00)
    else $error("warning without detail");
  a_fault_detail: assert property (replyOut.response[7] |-> replyOut.fault != 8'h00)
    else $error("fault without detail");
  a_fault_outs: assert property (replyOut.response[7] |-> !replyOut.response[0])
    else $error("outputs active with fault");
endmodule : isdb_diag_monitor

bind isdb_diag_bytes isdb_diag_monitor MON (.clk(clk), .arst_n(arst_n),
  .xchgStrobe(xchgStrobe), .xchgOk(xchgOk), .requestCommandByte(requestCommandByte),
  .senseIn(senseIn), .magnetOn(magnetOn), .safetyOutputA(safetyOutputA),
  .safetyOutputB(safetyOutputB), .replyOut(replyOut));

// [sim/isdb_gateway_model.sv]
/*
  Gateway model: makes one chain exchange per call of its exchange task.
  Assumes the caller waits for each call to return before the next.
*/
`timescale 1ns/1ps
module isdb_gateway_model (
  // Clock
  input wire logic   clk,
  // Exchange towards the device
  output logic       xchgStrobe,
  output logic       xchgOk,
  output logic [7:0] requestCommandByte
);
  // Idle levels at time zero
  initial begin
    xchgStrobe = 1'b0;
    xchgOk = 1'b1;
    requestCommandByte = 8'h00;
  end
  // Six-cycle phases, the minimum the monitor assumes, so a slow sync never misses one
  task automatic exchange(input logic [7:0] req, input logic ok);
    @(posedge clk);
    xchgStrobe <= 1'b1;
    xchgOk <= ok;
    requestCommandByte <= req;
    repeat (6) @(posedge clk);
    xchgStrobe <= 1'b0;
    requestCommandByte <= ~req; // Stale byte never looks fresh
    repeat (6) @(posedge clk);
  endtask : exchange
endmodule : isdb_gateway_model

// [sim/testbench.sv]
/*
  Self-checking bench for the diagnostic byte set: table of exchanges, then reset.
  Assumes the design package and the gateway model are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [13:0] sense;
    logic [7:0]  req;
    logic        ok;
    logic [7:0]  rsp;
    logic [7:0]  warn;
    logic [7:0]  flt;
  } isdb_row_t;
  logic                  clk;
  logic                  arst_n;
  logic                  xchgStrobe;
  logic                  xchgOk;
  logic [7:0]            requestCommandByte;
  isdb_pkg::isdb_sense_t senseIn;
  logic                  magnetOn;
  logic                  safetyOutputA;
  logic                  safetyOutputB;
  isdb_pkg::isdb_reply_t replyOut;
  logic                  expMag;
  int                    errTotal;
  int                    cmpCount;
  // Sense, request, ok, then expected response, warning and fault bytes
  isdb_row_t rows [20] = '{
    {14'h3d80, 8'h01, 1'h1, 8'h37, 8'h00, 8'h00}, {14'h3d88, 8'h01, 1'h1, 8'h77, 8'h08, 8'h00},
    {14'h3dc0, 8'h01, 1'h1, 8'h77, 8'h01, 8'h00}, {14'h3da0, 8'h01, 1'h1, 8'h77, 8'h02, 8'h00},
    {14'h3d90, 8'h01, 1'h1, 8'h77, 8'h04, 8'h00}, {14'h3f80, 8'h01, 1'h1, 8'h35, 8'h00, 8'h00},
    {14'h3980, 8'h00, 1'h1, 8'h35, 8'h00, 8'h00}, {14'h3d00, 8'h01, 1'h1, 8'h26, 8'h00, 8'h00},
    {14'h3d81, 8'h01, 1'h1, 8'hf6, 8'h80, 8'h80}, {14'h3d80, 8'h01, 1'h1, 8'hb6, 8'h00, 8'h80},
    {14'h3d80, 8'h81, 1'h1, 8'hb6, 8'h00, 8'h80}, {14'h3d80, 8'h01, 1'h1, 8'h37, 8'h00, 8'h00},
    {14'h3d80, 8'h00, 1'h0, 8'h77, 8'h40, 8'h00}, {14'h3d80, 8'h01, 1'h1, 8'h37, 8'h00, 8'h00},
    {14'h3d84, 8'h01, 1'h1, 8'hb6, 8'h00, 8'h10}, {14'h1180, 8'h01, 1'h1, 8'h30, 8'h00, 8'h00},
    {14'h3d80, 8'h01, 1'h1, 8'h37, 8'h00, 8'h00}, {14'h3d82, 8'h01, 1'h1, 8'hf6, 8'h20, 8'h20},
    {14'h3d80, 8'h81, 1'h1, 8'hb6, 8'h00, 8'h20}, {14'h3d80, 8'h01, 1'h1, 8'h37, 8'h00, 8'h00}};

  // ********
  // Design and partner
  // ********
  isdb_diag_bytes DUT (.clk(clk), .arst_n(arst_n), .xchgStrobe(xchgStrobe), .xchgOk(xchgOk),
    .requestCommandByte(requestCommandByte), .senseIn(senseIn), .magnetOn(magnetOn),
    .safetyOutputA(safetyOutputA), .safetyOutputB(safetyOutputB), .replyOut(replyOut));
  isdb_gateway_model GW (.clk(clk), .xchgStrobe(xchgStrobe), .xchgOk(xchgOk),
    .requestCommandByte(requestCommandByte));

  // Compare one byte and count it
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Counts, verdict and stop
  task automatic endSim;
    $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : endSim

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Main sequence; rows 10 and 11 pulse reset bit 7 high then low, row 15 opens the guard,
  // rows 17 to 19 latch an internal error and clear it again through bit 7
  initial begin
    arst_n = 1'b0;
    senseIn = '0;
    expMag = 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk(replyOut[23:16], 8'h00);
    for (int i = 0; i < 20; i++) begin
      senseIn <= rows[i].sense;
      if (rows[i].ok) begin
        expMag = rows[i].req[0];
      end
      repeat (2) GW.exchange(rows[i].req, rows[i].ok);
      chk(replyOut.response, rows[i].rsp);
      chk(replyOut.warning, rows[i].warn);
      chk(replyOut.fault, rows[i].flt);
      chk({5'h00, magnetOn, safetyOutputA, safetyOutputB},
          {5'h00, expMag, {2{rows[i].rsp[0]}}});
    end
    // Mid-run reset clears everything at once, without waiting for a clock
    arst_n <= 1'b0;
    #1;
    chk({5'h00, magnetOn, safetyOutputA, safetyOutputB}, 8'h00);
    chk(replyOut[7:0], 8'h00);
    @(posedge clk);
    arst_n <= 1'b1;
    repeat (10) @(posedge clk);
    // Exchanges after the second release must work as after the first
    repeat (2) GW.exchange(8'h01, 1'b1);
    chk(replyOut.response, 8'h37);
    chk({7'h00, magnetOn}, 8'h01);
    endSim();
  end

  // Watchdog: the table needs under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    errTotal++;
    endSim();
  end
endmodule : testbench
